/* File: design/hss_top.sv */
// HDLC serial port status logic with receive and transmit byte buffers.
// Assumes framing, CRC and bit stuffing sit outside on the same clock,
// so their strobes need no synchroniser; registers over AXI4-Lite.
//
// Local design decisions: register access over AXI4-Lite and the address map.
module hss_top
  import hss_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [HSS_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [HSS_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Receiver side
  input wire logic rx_push_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_short_i,
  input wire logic [1:0] rx_frame_status_i,
  // Transmitter side
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  output logic tx_last_o,
  input wire logic tx_take_i,
  input wire logic tx_crc_done_i,
  input wire logic tx_abort_done_i,
  output logic tx_shared_flag_o,
  // Requests
  output logic rx_irq_req_o,
  output logic tx_irq_req_o,
  output logic irq_o
);

  // Bus state
  logic awready_reg;
  logic wready_reg;
  logic [HSS_ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  // Block state
  logic [7:0] rx_data_reg;
  logic [1:0] rx_fs_reg;
  logic rx_short_reg;
  logic rx_full_reg;
  logic ovr_reg;
  logic [7:0] tx_data_reg;
  logic tx_last_reg;
  logic tx_full_reg;
  logic txi_pend_reg;
  logic [1:0] txi_cause_reg;
  logic share_reg;
  logic [HSS_EV_W-1:0] ev_reg;
  logic [HSS_EV_W-1:0] mask_reg;
  logic irq_reg;

  function automatic logic is_reg(input logic [HSS_ADDR_W-1:0] a, input logic [7:0] ofs);
    is_reg = (a[HSS_ADDR_W-1:2] == ofs[HSS_ADDR_W-1:2]);
  endfunction

  // Write path: address and data captured in any order, then performed once
  wire aw_take = s_axi_awvalid_i && awready_reg;
  wire w_take = s_axi_wvalid_i && wready_reg;
  wire wr_go = !awready_reg && !wready_reg && !bvalid_reg;
  wire b_done = bvalid_reg && s_axi_bready_i;
  wire wa_rx = is_reg(aw_addr_reg, HSS_RXDATA_OFS);
  wire wa_tx = is_reg(aw_addr_reg, HSS_TXDATA_OFS);
  wire wa_st = is_reg(aw_addr_reg, HSS_STATUS_OFS);
  wire wa_ev = is_reg(aw_addr_reg, HSS_EVENT_OFS);
  wire wa_mk = is_reg(aw_addr_reg, HSS_MASK_OFS);
  wire wa_ok = wa_rx || wa_tx || wa_st || wa_ev || wa_mk;
  // Data byte lane needed for a transmit load; a transmit write without byte lane 0 is dropped
  wire tx_wr = wr_go && wa_tx && w_strb_reg[0];
  wire st_wr = wr_go && wa_st;
  wire ev_wr = wr_go && wa_ev && w_strb_reg[0];
  wire mk_wr = wr_go && wa_mk && w_strb_reg[0];

  // Read path
  wire ar_take = s_axi_arvalid_i && arready_reg;
  wire r_done = rvalid_reg && s_axi_rready_i;
  wire ra_rx = is_reg(s_axi_araddr_i, HSS_RXDATA_OFS);
  wire ra_tx = is_reg(s_axi_araddr_i, HSS_TXDATA_OFS);
  wire ra_st = is_reg(s_axi_araddr_i, HSS_STATUS_OFS);
  wire ra_ev = is_reg(s_axi_araddr_i, HSS_EVENT_OFS);
  wire ra_mk = is_reg(s_axi_araddr_i, HSS_MASK_OFS);
  wire ra_ok = ra_rx || ra_tx || ra_st || ra_ev || ra_mk;
  wire rx_rd = ar_take && ra_rx;

  // Receive buffer
  wire rx_full_next = rx_push_i || (rx_full_reg && !rx_rd);
  // Overrun only when the old byte is still unread in the same cycle
  wire ovr_evt = rx_push_i && rx_full_reg && !rx_rd;
  wire ovr_next = ovr_evt || (ovr_reg && !rx_rd);

  // Transmit buffer and interrupt cause
  wire tx_took = tx_take_i && tx_full_reg;
  wire tx_full_next = tx_wr || (tx_full_reg && !tx_took);
  wire empty_evt = tx_took && !tx_last_reg;
  wire txi_set = empty_evt || tx_crc_done_i || tx_abort_done_i;
  wire txi_clr = tx_wr || st_wr;
  // Set wins over a clear in the same cycle
  wire txi_pend_next = txi_set || (txi_pend_reg && !txi_clr);
  wire [1:0] txi_cause_next = tx_abort_done_i ? HSS_CAUSE_ABORT :
                              tx_crc_done_i ? HSS_CAUSE_CRC :
                              empty_evt ? HSS_CAUSE_EMPTY :
                              txi_cause_reg;
  // Reload in answer to the CRC interrupt lets the closing flag open the next frame
  wire share_set = tx_wr && txi_pend_reg && (txi_cause_reg == HSS_CAUSE_CRC);
  wire share_next = share_set || (share_reg && !tx_crc_done_i && !tx_abort_done_i);

  // Status byte
  wire [7:0] status_val = {rx_full_reg, rx_fs_reg[1], ovr_reg, rx_fs_reg[0],
                           tx_full_reg, txi_cause_reg, rx_short_reg};

  // Sticky events, write one to clear, set wins
  wire [HSS_EV_W-1:0] ev_set = {txi_set, ovr_evt, rx_push_i};
  wire [HSS_EV_W-1:0] ev_clr = ev_wr ? w_data_reg[HSS_EV_W-1:0] : {HSS_EV_W{1'b0}};
  wire [HSS_EV_W-1:0] ev_next = ev_set | (ev_reg & ~ev_clr);
  wire [HSS_EV_W-1:0] mask_next = mk_wr ? w_data_reg[HSS_EV_W-1:0] : mask_reg;
  wire irq_next = |(ev_next & mask_next);

  wire [31:0] rd_val = ra_rx ? {24'h000000, rx_data_reg} :
                       ra_tx ? {23'h000000, tx_last_reg, tx_data_reg} :
                       ra_st ? {24'h000000, status_val} :
                       ra_ev ? {29'h00000000, ev_reg} :
                       ra_mk ? {29'h00000000, mask_reg} : 32'h00000000;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= HSS_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awready_reg <= 1'b0;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (w_take) begin
        wready_reg <= 1'b0;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wa_ok ? HSS_RESP_OKAY : HSS_RESP_SLVERR;
      end
      if (b_done) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= HSS_RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_val;
      rresp_reg <= ra_ok ? HSS_RESP_OKAY : HSS_RESP_SLVERR;
    end else if (r_done) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_data_reg <= 8'h00;
      rx_fs_reg <= HSS_FS_DATA;
      rx_short_reg <= 1'b0;
    end else if (rx_push_i) begin
      // Newest byte overwrites an unread one
      rx_data_reg <= rx_byte_i;
      rx_fs_reg <= rx_frame_status_i;
      rx_short_reg <= rx_short_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_data_reg <= 8'h00;
      tx_last_reg <= 1'b0;
    end else if (tx_wr) begin
      // A write while full replaces the waiting byte
      tx_data_reg <= w_data_reg[7:0];
      tx_last_reg <= w_data_reg[HSS_TX_LAST_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_full_reg <= 1'b0;
      ovr_reg <= 1'b0;
      tx_full_reg <= 1'b0;
      txi_pend_reg <= 1'b0;
      txi_cause_reg <= HSS_CAUSE_EMPTY;
      share_reg <= 1'b0;
      ev_reg <= {HSS_EV_W{1'b0}};
      mask_reg <= HSS_MASK_RESET;
      irq_reg <= 1'b0;
    end else begin
      rx_full_reg <= rx_full_next;
      ovr_reg <= ovr_next;
      tx_full_reg <= tx_full_next;
      txi_pend_reg <= txi_pend_next;
      txi_cause_reg <= txi_cause_next;
      share_reg <= share_next;
      ev_reg <= ev_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign tx_valid_o = tx_full_reg;
  assign tx_byte_o = tx_data_reg;
  assign tx_last_o = tx_last_reg;
  assign tx_shared_flag_o = share_reg;
  assign rx_irq_req_o = rx_full_reg;
  assign tx_irq_req_o = txi_pend_reg;
  assign irq_o = irq_reg;

endmodule

/* File: design/hss_pkg.sv */
// Constants for the HDLC serial status block: offsets, fields, codes.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package hss_pkg;
  // Register byte offsets
  localparam logic [7:0] HSS_RXDATA_OFS = 8'h00;
  localparam logic [7:0] HSS_TXDATA_OFS = 8'h04;
  localparam logic [7:0] HSS_STATUS_OFS = 8'h08;
  localparam logic [7:0] HSS_EVENT_OFS = 8'h0c;
  localparam logic [7:0] HSS_MASK_OFS = 8'h10;
  localparam int HSS_ADDR_W = 8;
  // Status register fields
  localparam int HSS_ST_RXRDY = 7;
  localparam int HSS_ST_FS_HI = 6;
  localparam int HSS_ST_OVR = 5;
  localparam int HSS_ST_FS_LO = 4;
  localparam int HSS_ST_TXBUSY = 3;
  localparam int HSS_ST_CAUSE_HI = 2;
  localparam int HSS_ST_CAUSE_LO = 1;
  localparam int HSS_ST_SHORT = 0;
  // Transmit data register: bit 8 marks the last byte of a frame
  localparam int HSS_TX_LAST_BIT = 8;
  // Event and mask register fields
  localparam int HSS_EV_W = 3;
  localparam int HSS_EV_RXBYTE = 0;
  localparam int HSS_EV_OVR = 1;
  localparam int HSS_EV_TXINT = 2;
  localparam logic [HSS_EV_W-1:0] HSS_MASK_RESET = 3'h0;
  // Transmit interrupt causes
  localparam logic [1:0] HSS_CAUSE_EMPTY = 2'h0;
  localparam logic [1:0] HSS_CAUSE_CRC = 2'h1;
  localparam logic [1:0] HSS_CAUSE_ABORT = 2'h2;
  // Receive frame status codes
  localparam logic [1:0] HSS_FS_DATA = 2'h0;
  localparam logic [1:0] HSS_FS_ABORT = 2'h1;
  localparam logic [1:0] HSS_FS_END_OK = 2'h2;
  localparam logic [1:0] HSS_FS_END_BAD = 2'h3;
  // AXI responses
  localparam logic [1:0] HSS_RESP_OKAY = 2'h0;
  localparam logic [1:0] HSS_RESP_SLVERR = 2'h2;
endpackage

/* File: sim/hss_station.sv */
// Remote station model: takes transmit bytes, reports CRC and Abort done.
// Same clock as the block; all strobes are one-cycle pulses.
module hss_station (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic abort_i,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  output logic take_o,
  output logic crc_done_o,
  output logic abort_done_o
);
  logic [3:0] crc_reg;
  logic [1:0] ab_reg;
  // Go low stalls the station, so the buffer can be seen full
  wire take_next = go_i && tx_valid_i && !take_o;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      take_o <= 1'b0;
      crc_reg <= 4'h0;
      ab_reg <= 2'h0;
    end else begin
      take_o <= take_next;
      crc_reg <= (take_next && tx_last_i) ? 4'h6 : crc_reg - 4'(crc_reg != 4'h0);
      ab_reg <= abort_i ? 2'h3 : ab_reg - 2'(ab_reg != 2'h0);
    end
  end
  assign crc_done_o = crc_reg == 4'h1;
  assign abort_done_o = ab_reg == 2'h1;
endmodule

/* File: sim/hss_checker.sv */
// Port assertions for the HDLC status block.
// Bound to hss_top; sees its ports only, one clock domain.
module hss_checker
  import hss_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [HSS_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic tx_valid_o,
  input wire logic tx_last_o,
  input wire logic tx_take_i,
  input wire logic tx_crc_done_i,
  input wire logic tx_abort_done_i,
  input wire logic tx_shared_flag_o,
  input wire logic rx_push_i,
  input wire logic rx_irq_req_o,
  input wire logic tx_irq_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [HSS_ADDR_W-1:0] aw_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) aw_reg <= '0;
    else if (s_axi_awvalid_i && s_axi_awready_o) aw_reg <= s_axi_awaddr_i;
  end
  // Set beats clear, so a same-edge event excuses the clear
  wire set_now = (tx_take_i && tx_valid_o && !tx_last_o) || tx_crc_done_i || tx_abort_done_i;
  wire clr_wr = aw_reg[7:2] == HSS_STATUS_OFS[7:2] || aw_reg[7:2] == HSS_TXDATA_OFS[7:2];
  rx_req_a: assert property (rx_push_i |=> rx_irq_req_o) else $error("rx request");
  tx_take_a: assert property (tx_take_i && tx_valid_o && !tx_last_o |=> tx_irq_req_o) else $error("take irq");
  tx_empty_a: assert property (tx_take_i && tx_valid_o |=> !tx_valid_o || $rose(s_axi_bvalid_o))
    else $error("busy");
  tx_clear_a: assert property ($rose(s_axi_bvalid_o) && clr_wr && !$past(set_now) |-> !tx_irq_req_o)
    else $error("tx clear");
  crc_irq_a: assert property (tx_crc_done_i |=> tx_irq_req_o) else $error("crc irq");
  abort_irq_a: assert property (tx_abort_done_i |=> tx_irq_req_o) else $error("abort irq");
  flag_set_a: assert property ($rose(tx_shared_flag_o) |-> $rose(s_axi_bvalid_o)) else $error("flag set");
  flag_clr_a: assert property ((tx_crc_done_i || tx_abort_done_i) ##1 !$rose(s_axi_bvalid_o) |-> !tx_shared_flag_o)
    else $error("flag clear");
  cover property (tx_shared_flag_o);
  cover property (tx_abort_done_i);
  cover property (rx_push_i && rx_irq_req_o);
endmodule
bind hss_top hss_checker hss_checker_i (.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_bvalid_o, .tx_valid_o, .tx_last_o, .tx_take_i, .tx_crc_done_i, .tx_abort_done_i, .tx_shared_flag_o,
  .rx_push_i, .rx_irq_req_o, .tx_irq_req_o);

/* File: sim/testbench.sv */
// Self-checking bench for the HDLC status block.
// Drives AXI4-Lite and receiver strobes; a station model takes bytes.
module testbench
  import hss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, push = 0, shrt = 0, go = 0, ab = 0;
  logic [7:0] awa = 0, ara = 0, rxb = 0;
  logic [31:0] wd = 0, rdat, rdata, seed = 32'hd17243de;
  logic [3:0] ws = 4'hf;
  logic [1:0] fs = 0, bresp, rresp;
  logic awr, wr_r, bv, arr, rv, txv, txl, take, crc, abd, flag, rxq, txq, irq;
  logic [7:0] txb;
  int err_total = 0, checks_done = 0;
  hss_top hss_top_i (.clk_i, .rst_i, .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy), .rx_push_i(push),
    .rx_byte_i(rxb), .rx_short_i(shrt), .rx_frame_status_i(fs), .tx_valid_o(txv), .tx_byte_o(txb), .tx_last_o(txl),
    .tx_take_i(take), .tx_crc_done_i(crc), .tx_abort_done_i(abd), .tx_shared_flag_o(flag), .rx_irq_req_o(rxq),
    .tx_irq_req_o(txq), .irq_o(irq));
  hss_station hss_station_i (.clk_i, .rst_i, .go_i(go), .abort_i(ab), .tx_valid_i(txv), .tx_last_i(txl),
    .take_o(take), .crc_done_o(crc), .abort_done_o(abd));
  initial forever #25 clk_i = ~clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] st(logic rdy, logic [1:0] f, logic ovr, logic busy, logic [1:0] cs, logic sh);
    return {24'h0, rdy, f[1], ovr, f[0], busy, cs, sh};
  endfunction
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Seen value is copied at the call, so callers settle first where needed
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = HSS_RESP_OKAY,
                    input logic [3:0] s = 4'hf);
    logic aw_d, w_d;
    aw_d = 0;
    w_d = 0;
    @(posedge clk_i);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge clk_i);
      if (awr && !aw_d) begin aw_d = 1; awv <= 1'b0; end
      if (wr_r && !w_d) begin w_d = 1; wv <= 1'b0; end
    end
    do @(posedge clk_i); while (!bv);
    brdy <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = HSS_RESP_OKAY);
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do @(posedge clk_i); while (!arr);
    arv <= 1'b0;
    do @(posedge clk_i); while (!rv);
    rrdy <= 1'b0;
    d = rdata;
    chk(32'(rresp), 32'(er));
  endtask
  task automatic push_rx(input logic [7:0] b, input logic s, input logic [1:0] f);
    @(posedge clk_i);
    push <= 1'b1;
    rxb <= b;
    shrt <= s;
    fs <= f;
    @(posedge clk_i);
    push <= 1'b0;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    end_of_test();
  end
  initial begin
    logic [31:0] r;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(HSS_MASK_OFS, rdat);
    chk(rdat, 32'h0);
    rd(8'h14, rdat, HSS_RESP_SLVERR);
    wr(8'h14, 32'h0, HSS_RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      push_rx(r[7:0], r[8], 2'(i));
      if (i[2]) push_rx(r[7:0], r[8], 2'(i));
      // Let the push edge land before looking
      #1 chk(32'(rxq), 32'h1);
      rd(HSS_STATUS_OFS, rdat);
      chk(rdat, st(1'b1, 2'(i), i[2], 1'b0, 2'h0, r[8]));
      rd(HSS_RXDATA_OFS, rdat);
      chk(rdat, {24'h0, r[7:0]});
      rd(HSS_STATUS_OFS, rdat);
      chk(rdat & 32'ha0, 32'h0);
    end
    wr(HSS_MASK_OFS, 32'h4);
    wr(HSS_TXDATA_OFS, 32'h5a);
    chk(32'({txv, txl, txb}), 32'h25a);
    rd(HSS_TXDATA_OFS, rdat);
    chk(rdat, 32'h5a);
    rd(HSS_STATUS_OFS, rdat);
    chk(rdat & 32'h0e, st(0, 0, 0, 1, 0, 0));
    @(posedge clk_i) go <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(32'(txq), 32'h1);
    rd(HSS_STATUS_OFS, rdat);
    chk(rdat & 32'h0e, st(0, 0, 0, 0, HSS_CAUSE_EMPTY, 0));
    wr(HSS_STATUS_OFS, rnd());
    chk(32'(txq), 32'h0);
    wr(HSS_TXDATA_OFS, 32'h1a5);
    repeat (3) @(posedge clk_i);
    chk(32'(txq), 32'h0);
    repeat (8) @(posedge clk_i);
    rd(HSS_STATUS_OFS, rdat);
    chk(rdat & 32'h0e | 32'(txq), st(0, 0, 0, 0, HSS_CAUSE_CRC, 1));
    @(posedge clk_i) go <= 1'b0;
    wr(HSS_TXDATA_OFS, 32'h33);
    chk(32'({flag, txq, txv}), 32'h5);
    @(posedge clk_i) ab <= 1'b1;
    @(posedge clk_i) ab <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk(32'({txq, flag, irq}), 32'h5);
    rd(HSS_STATUS_OFS, rdat);
    chk(rdat & 32'h0e, st(0, 0, 0, 1, HSS_CAUSE_ABORT, 0));
    rd(HSS_EVENT_OFS, rdat);
    chk(rdat, 32'h7);
    wr(HSS_MASK_OFS, 32'h0);
    chk(32'(irq), 32'h0);
    wr(HSS_EVENT_OFS, 32'h7);
    rd(HSS_EVENT_OFS, rdat);
    chk(rdat, 32'h0);
    wr(HSS_MASK_OFS, 32'h7);
    chk(32'(irq), 32'h0);
    push_rx(8'h11, 1'b0, HSS_FS_END_OK);
    @(posedge clk_i) go <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(32'({irq, txv}), 32'h2);
    // Status write ignores strobes; a transmit load needs byte lane 0
    wr(HSS_STATUS_OFS, 32'h0, HSS_RESP_OKAY, 4'h0);
    chk(32'(txq), 32'h0);
    wr(HSS_TXDATA_OFS, 32'h1ff, HSS_RESP_OKAY, 4'he);
    chk(32'({txv, txl, txb}), 32'h033);
    end_of_test();
  end
endmodule
